// ===== core/aspp_char_if.sv
// Carrier for received characters from the receiver to the queue.
`timescale 1ns/1ps
`default_nettype none
interface aspp_char_if;
    logic push;
    logic [7:0] data;
    logic ferr;
    modport rx_end (output push, output data, output ferr);
    modport queue_end (input push, input data, input ferr);
endinterface
`default_nettype wire

// ===== core/aspp_pkg.sv
// Shared constants and types for the asynchronous serial port pin logic.
package aspp_pkg;

    // ********************************************
    // Framing and defaults
    // ********************************************
    localparam int ASPP_DATA_W = 8;
    localparam int ASPP_BIT_CYCLES_DEF = 16;
    localparam int ASPP_RXQ_DEPTH_DEF = 4;
    localparam int ASPP_RTS_LEVEL_DEF = 3;
    localparam logic ASPP_MARK = 1'b1;
    localparam logic ASPP_START_LVL = 1'b0;
    localparam logic ASPP_STOP_LVL = 1'b1;
    localparam logic [3:0] ASPP_TX_SHIFTS = 4'h9;
    localparam logic [2:0] ASPP_LAST_BIT = 3'h7;

    // ********************************************
    // State encodings
    // ********************************************
    typedef enum logic [1:0] {
        ASPP_TX_IDLE = 2'b00,
        ASPP_TX_SHIFT = 2'b01
    } aspp_tx_state_t;

    typedef enum logic [1:0] {
        ASPP_RX_IDLE = 2'b00,
        ASPP_RX_START = 2'b01,
        ASPP_RX_DATA = 2'b10,
        ASPP_RX_STOP = 2'b11
    } aspp_rx_state_t;

endpackage

// ===== core/aspp_rx.sv
// Receive deserialiser: start detect, mid-bit sampling, stop check.
`timescale 1ns/1ps
`default_nettype none
module aspp_rx
    import aspp_pkg::*;
#(
    parameter int BIT_CYCLES = ASPP_BIT_CYCLES_DEF
) (
    input wire logic i_core_clk,         // Core clock
    input wire logic i_rst_n,            // Synchronous reset, active low
    input wire logic i_run,              // Serial clock running
    input wire logic i_rx,               // Selected receive line
    aspp_char_if.rx_end o_char           // Received character
);
    localparam int CW = $clog2(BIT_CYCLES);
    localparam logic [CW-1:0] HALF_M1 = CW'(BIT_CYCLES / 2 - 1);
    localparam logic [CW-1:0] FULL_M1 = CW'(BIT_CYCLES - 1);

    aspp_rx_state_t state_q;
    logic [CW-1:0] cnt_q;
    logic [2:0] idx_q;
    logic [7:0] sh_q;
    wire logic due = i_run && (cnt_q == '0);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_q <= ASPP_RX_IDLE;
            cnt_q <= '0;
            idx_q <= 3'h0;
            sh_q <= 8'h00;
            o_char.push <= 1'b0;
            o_char.data <= 8'h00;
            o_char.ferr <= 1'b0;
        end else begin
            o_char.push <= 1'b0;
            if (i_run && cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
            unique case (state_q)
                ASPP_RX_IDLE: begin
                    if (i_run && i_rx == ASPP_START_LVL) begin
                        state_q <= ASPP_RX_START;
                        cnt_q <= HALF_M1;
                    end
                end
                ASPP_RX_START: begin
                    if (due) begin
                        // A glitch shorter than half a bit is dropped.
                        state_q <= (i_rx == ASPP_START_LVL) ?
                            ASPP_RX_DATA : ASPP_RX_IDLE;
                        cnt_q <= FULL_M1;
                        idx_q <= 3'h0;
                    end
                end
                ASPP_RX_DATA: begin
                    if (due) begin
                        sh_q <= {i_rx, sh_q[7:1]};
                        idx_q <= idx_q + 1'b1;
                        cnt_q <= FULL_M1;
                        if (idx_q == ASPP_LAST_BIT) begin
                            state_q <= ASPP_RX_STOP;
                        end
                    end
                end
                ASPP_RX_STOP: begin
                    if (due) begin
                        o_char.push <= 1'b1;
                        o_char.data <= sh_q;
                        o_char.ferr <= (i_rx != ASPP_STOP_LVL);
                        state_q <= ASPP_RX_IDLE;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    rx_lsb_first_a: assert property (
        (state_q == ASPP_RX_DATA && due) |=> sh_q[7] == $past(i_rx))
        else $error("received bit not shifted in from the top");
    rx_stop_check_a: assert property (
        (state_q == ASPP_RX_STOP && due) |=>
            o_char.push && o_char.ferr == ($past(i_rx) != ASPP_STOP_LVL))
        else $error("stop bit not checked at end of character");

endmodule
`default_nettype wire

// ===== core/aspp_top.sv
// Asynchronous serial port pin logic: transmit, receive queue, wake, flow.
`timescale 1ns/1ps
`default_nettype none
module aspp_top
    import aspp_pkg::*;
#(
    parameter int BIT_CYCLES = ASPP_BIT_CYCLES_DEF,
    parameter int RXQ_DEPTH = ASPP_RXQ_DEPTH_DEF,
    parameter int RTS_LEVEL = ASPP_RTS_LEVEL_DEF
) (
    input wire logic i_core_clk,          // Core clock, 200 MHz
    input wire logic i_rst_n,             // Synchronous reset, active low
    input wire logic i_tx_enable,         // Transmitter enable
    input wire logic i_loopback,          // Local loopback mode
    input wire logic [7:0] i_tx_data,     // Character to send
    input wire logic i_tx_valid,          // Character offered
    output logic o_tx_ready,              // Holding slot free
    output logic o_serial_tx_out,         // Transmit data pin
    input wire logic i_serial_rx_in,      // Receive data pin
    input wire logic i_peer_ready_in,     // Clear-to-send, high = ready
    output logic o_ask_to_send_out,       // Request-to-send, high = ask
    input wire logic i_rts_auto,          // Request follows queue fill
    input wire logic i_rts_manual,        // Request level in manual mode
    input wire logic i_power_down,        // Rising edge stops serial clock
    output logic o_clk_running,           // Serial clock running
    output logic [7:0] o_rx_data,         // Head of receive queue
    output logic o_rx_valid,              // Queue not empty
    input wire logic i_rx_ready,          // Pop head of queue
    output logic o_rx_frame_err,          // Pulse: bad stop bit received
    output logic o_rx_overrun             // Pulse: character lost, queue full
);
    // ********************************************
    // Parameter checks and derived widths
    // ********************************************
    localparam int CW = $clog2(BIT_CYCLES);
    localparam int PW = $clog2(RXQ_DEPTH);
    localparam int NW = $clog2(RXQ_DEPTH + 1);
    localparam logic [CW-1:0] HALF_M1 = CW'(BIT_CYCLES / 2 - 1);
    localparam logic [NW-1:0] QFULL = NW'(RXQ_DEPTH);
    localparam logic [NW-1:0] QLVL = NW'(RTS_LEVEL);

    if (BIT_CYCLES < 4 || BIT_CYCLES % 2 != 0) begin : g_bad_bit
        $error("BIT_CYCLES must be even and at least 4");
    end
    if (RXQ_DEPTH < 2 || (RXQ_DEPTH & (RXQ_DEPTH - 1)) != 0) begin : g_bad_q
        $error("RXQ_DEPTH must be a power of two, at least 2");
    end
    if (RTS_LEVEL < 1 || RTS_LEVEL > RXQ_DEPTH) begin : g_bad_lvl
        $error("RTS_LEVEL must lie between 1 and RXQ_DEPTH");
    end

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return PW'(p + 1'b1);
    endfunction

    // ********************************************
    // Serial clock and power-down wake
    // ********************************************
    logic run_q;
    logic pd_prev_q;
    logic rx_prev_q;
    logic sclk_q;
    logic [CW-1:0] hc_q;

    wire logic rx_edge = (i_serial_rx_in != rx_prev_q);
    wire logic pd_rise = i_power_down && !pd_prev_q;
    wire logic half_done = run_q && (hc_q == HALF_M1);
    wire logic fall_tick = half_done && sclk_q;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            run_q <= 1'b1;
            pd_prev_q <= 1'b0;
            rx_prev_q <= ASPP_MARK;
        end else begin
            pd_prev_q <= i_power_down;
            rx_prev_q <= i_serial_rx_in;
            // Wake wins over a stop request in the same cycle.
            if (rx_edge) begin
                run_q <= 1'b1;
            end else if (pd_rise) begin
                run_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            hc_q <= '0;
            sclk_q <= 1'b0;
        end else if (half_done) begin
            hc_q <= '0;
            sclk_q <= ~sclk_q;
        end else if (run_q) begin
            hc_q <= hc_q + 1'b1;
        end
    end

    assign o_clk_running = run_q;

    // ********************************************
    // Transmitter
    // ********************************************
    aspp_tx_state_t tx_state_q;
    logic full_q;
    logic [7:0] hold_q;
    logic [8:0] sh_q;
    logic [3:0] left_q;
    logic line_q;
    logic tx_out_q;
    logic tx_ready_q;

    wire logic accept = i_tx_valid && tx_ready_q;
    wire logic tx_idle = (tx_state_q == ASPP_TX_IDLE);
    wire logic start = fall_tick && tx_idle && full_q && i_tx_enable
        && i_peer_ready_in;
    wire logic full_d = accept || (full_q && !start);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            full_q <= 1'b0;
            hold_q <= 8'h00;
            tx_ready_q <= 1'b0;
        end else begin
            full_q <= full_d;
            tx_ready_q <= !full_d;
            if (accept) begin
                hold_q <= i_tx_data;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_state_q <= ASPP_TX_IDLE;
            sh_q <= 9'h1ff;
            left_q <= 4'h0;
            line_q <= ASPP_MARK;
        end else if (start) begin
            tx_state_q <= ASPP_TX_SHIFT;
            line_q <= ASPP_START_LVL;
            sh_q <= {ASPP_STOP_LVL, hold_q};
            left_q <= ASPP_TX_SHIFTS;
        end else if (fall_tick && !tx_idle) begin
            if (left_q == 4'h0) begin
                tx_state_q <= ASPP_TX_IDLE;
                line_q <= ASPP_MARK;
            end else begin
                line_q <= sh_q[0];
                sh_q <= {ASPP_MARK, sh_q[8:1]};
                left_q <= left_q - 1'b1;
            end
        end
    end

    // The pin is masked rather than the shifter stopped, so a disable in
    // mid-character still lets the frame finish internally.
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            tx_out_q <= ASPP_MARK;
        end else begin
            tx_out_q <= (i_tx_enable && !i_loopback) ? line_q : ASPP_MARK;
        end
    end

    assign o_serial_tx_out = tx_out_q;
    assign o_tx_ready = tx_ready_q;

    // ********************************************
    // Receiver and receive queue
    // ********************************************
    aspp_char_if rx_ch ();
    wire logic rx_line = i_loopback ? line_q : i_serial_rx_in;

    aspp_rx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_rx (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_run(run_q),
        .i_rx(rx_line),
        .o_char(rx_ch)
    );

    logic [7:0] mem_q [RXQ_DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [NW-1:0] cnt_q;
    logic [7:0] head_q;
    logic valid_q;
    logic ferr_q;
    logic ovr_q;
    logic rts_q;

    wire logic push_ok = rx_ch.push && (cnt_q != QFULL);
    wire logic pop = valid_q && i_rx_ready;
    wire logic [PW-1:0] rd_d = pop ? ptr_inc(rd_q) : rd_q;
    wire logic [NW-1:0] cnt_d = NW'(cnt_q + push_ok - pop);
    // The head is rebuilt each cycle so that the data port is a flop even
    // when the queue goes from empty to one entry. An empty queue shows
    // zero, so storage that was never written cannot reach the pins.
    wire logic [7:0] head_d = (push_ok && rd_d == wr_q) ? rx_ch.data :
        (cnt_d == '0) ? 8'h00 : mem_q[rd_d];

    always_ff @(posedge i_core_clk) begin
        if (push_ok) begin
            mem_q[wr_q] <= rx_ch.data;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            head_q <= 8'h00;
            valid_q <= 1'b0;
            ferr_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            wr_q <= push_ok ? ptr_inc(wr_q) : wr_q;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            head_q <= head_d;
            valid_q <= (cnt_d != '0);
            ferr_q <= rx_ch.push && rx_ch.ferr;
            ovr_q <= rx_ch.push && !push_ok;
        end
    end

    // ********************************************
    // Request-to-send
    // ********************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rts_q <= 1'b0;
        end else begin
            rts_q <= i_rts_auto ? (cnt_q < QLVL) : i_rts_manual;
        end
    end

    assign o_rx_data = head_q;
    assign o_rx_valid = valid_q;
    assign o_rx_frame_err = ferr_q;
    assign o_rx_overrun = ovr_q;
    assign o_ask_to_send_out = rts_q;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence tx_begin_s;
        tx_idle ##1 !tx_idle;
    endsequence
    sequence wake_s;
        !run_q && rx_edge;
    endsequence

    tx_mark_hold_a: assert property (
        (!i_tx_enable || i_loopback || (tx_idle && line_q)) |=>
            o_serial_tx_out == ASPP_MARK)
        else $error("transmit pin left mark level while quiet");
    tx_fall_edge_a: assert property (
        $changed(line_q) |-> $past(fall_tick) && $past(sclk_q))
        else $error("transmit line changed off a falling edge");
    tx_lsb_first_a: assert property (
        (fall_tick && !tx_idle && left_q != 4'h0) |=>
            line_q == $past(sh_q[0]))
        else $error("transmit bit not taken from the low end");
    tx_peer_gate_a: assert property (
        tx_begin_s |-> $past(i_peer_ready_in) && !line_q)
        else $error("character started without peer ready");
    tx_stop_high_a: assert property (
        (!tx_idle && left_q == 4'h0) |-> line_q == ASPP_STOP_LVL)
        else $error("stop bit not high");
    clk_wake_a: assert property (
        wake_s |=> run_q ##1 (run_q || $past(pd_rise)))
        else $error("receive transition did not restart clock");
    rts_fill_a: assert property (
        (i_rts_auto && cnt_q >= QLVL) |=> !o_ask_to_send_out)
        else $error("request-to-send held with queue at level");
    rts_room_a: assert property (
        (i_rts_auto && cnt_q < QLVL) |=> o_ask_to_send_out)
        else $error("request-to-send dropped with queue room");

endmodule
`default_nettype wire

// ===== verification/aspp_peer_model.sv
// Behavioural model of the remote serial device on the far side.
`timescale 1ns/1ps
`default_nettype none
module aspp_peer_model #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic i_core_clk, // Core clock
    input wire logic i_line,     // Device transmit pin
    output logic o_line          // Device receive pin
);
    logic [7:0] got_q[$];
    logic [7:0] cap;
    logic stop_ok;

    initial begin
        o_line = 1'b1;
        stop_ok = 1'b1;
    end

    // ********************************************
    // Sender
    // ********************************************
    // A zero stop bit is only sent when a frame error is being provoked.
    task automatic send_char(input logic [7:0] c, input logic stop);
        logic [9:0] frm;
        frm = {stop, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            o_line <= frm[i];
            repeat (BIT_CYCLES) @(posedge i_core_clk);
        end
        o_line <= 1'b1;
    endtask

    // A one-cycle dip is shorter than half a bit, so it never frames.
    task automatic glitch();
        o_line <= 1'b0;
        @(posedge i_core_clk);
        o_line <= 1'b1;
    endtask

    // ********************************************
    // Receiver: mid-bit sampling of the device line
    // ********************************************
    always begin
        @(negedge i_line);
        repeat (BIT_CYCLES / 2) @(posedge i_core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge i_core_clk);
            cap[i] = i_line;
        end
        repeat (BIT_CYCLES) @(posedge i_core_clk);
        stop_ok = stop_ok & i_line;
        got_q.push_back(cap);
    end
endmodule
`default_nettype wire

// ===== verification/aspp_top_tb_top.sv
// Self-checking testbench for the serial port pin logic.
`timescale 1ns/1ps
`default_nettype none
module aspp_top_tb_top;
    import aspp_pkg::*;
    localparam int BC = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tx_en = 1'b1;
    logic loopb = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic tx_ready, tx_pin, rx_pin, rts, clk_run;
    logic peer_rdy = 1'b0;
    logic rts_auto = 1'b1;
    logic rts_man = 1'b0;
    logic pdown = 1'b0;
    logic [7:0] rx_data;
    logic rx_valid, ferr, ovr;
    logic rx_ready = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_ferr = 0;
    int n_ovr = 0;
    logic [7:0] d;

    always #2.5 clk = ~clk;

    aspp_top #(.BIT_CYCLES(BC), .RXQ_DEPTH(4), .RTS_LEVEL(3)) u_dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_tx_enable(tx_en),
        .i_loopback(loopb), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready), .o_serial_tx_out(tx_pin),
        .i_serial_rx_in(rx_pin), .i_peer_ready_in(peer_rdy),
        .o_ask_to_send_out(rts), .i_rts_auto(rts_auto),
        .i_rts_manual(rts_man), .i_power_down(pdown),
        .o_clk_running(clk_run), .o_rx_data(rx_data),
        .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
        .o_rx_frame_err(ferr), .o_rx_overrun(ovr));

    aspp_peer_model #(.BIT_CYCLES(BC)) u_peer (
        .i_core_clk(clk), .i_line(tx_pin), .o_line(rx_pin));

    always @(posedge clk) begin
        if (rst_n && ferr === 1'b1) n_ferr++;
        if (rst_n && ovr === 1'b1) n_ovr++;
    end

    // ********************************************
    // Tasks
    // ********************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic send_tx(input logic [7:0] c);
        @(posedge clk);
        tx_data <= c;
        tx_valid <= 1'b1;
        @(negedge clk);
        while (tx_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    task automatic pop(output logic [7:0] v);
        int n;
        n = 0;
        @(negedge clk);
        while (rx_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) n_mismatch++;
        v = rx_data;
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
        @(posedge clk);
    endtask

    // Checks that the pin holds mark for the span of 15 bit times.
    task automatic hold_mark();
        for (int i = 0; i < 15 * BC; i++) begin
            @(negedge clk);
            chk({7'h00, tx_pin}, 8'h01);
        end
    endtask

    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (u_peer.got_q.size() < n && k < 2000) begin
            @(posedge clk);
            k++;
        end
    endtask

    // ********************************************
    // Tests
    // ********************************************
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk({7'h00, tx_pin}, 8'h01);
        chk({7'h00, clk_run}, 8'h01);
        send_tx(8'ha5);
        for (int i = 0; i < 15 * BC; i++) begin
            @(negedge clk);
            chk({7'h00, tx_pin}, 8'h01);
        end
        chk({7'h00, tx_ready}, 8'h00);
        @(posedge clk);
        peer_rdy <= 1'b1;
        send_tx(8'h01);
        send_tx(8'h80);
        wait_got(3);
        chk(u_peer.got_q[0], 8'ha5);
        chk(u_peer.got_q[1], 8'h01);
        chk(u_peer.got_q[2], 8'h80);
        chk({7'h00, u_peer.stop_ok}, 8'h01);
        // A disabled transmitter keeps its character waiting in the slot
        // and sends it, looped back, once it is enabled again.
        tx_en <= 1'b0;
        send_tx(8'h5a);
        hold_mark();
        @(posedge clk);
        tx_en <= 1'b1;
        loopb <= 1'b1;
        send_tx(8'h96);
        hold_mark();
        pop(d);
        chk(d, 8'h5a);
        pop(d);
        chk(d, 8'h96);
        @(posedge clk);
        loopb <= 1'b0;
        repeat (4 * BC) @(posedge clk);
        u_peer.send_char(8'h3c, 1'b1);
        u_peer.send_char(8'hc3, 1'b1);
        repeat (3) @(posedge clk);
        chk({7'h00, rts}, 8'h01);
        u_peer.send_char(8'h7e, 1'b1);
        repeat (3) @(posedge clk);
        chk({7'h00, rts}, 8'h00);
        u_peer.send_char(8'h11, 1'b1);
        u_peer.send_char(8'h22, 1'b1);
        repeat (3) @(posedge clk);
        chk(n_ovr[7:0], 8'h01);
        pop(d);
        chk(d, 8'h3c);
        pop(d);
        chk(d, 8'hc3);
        pop(d);
        chk(d, 8'h7e);
        chk({7'h00, rts}, 8'h01);
        pop(d);
        chk(d, 8'h11);
        rts_auto <= 1'b0;
        repeat (3) @(posedge clk);
        chk({7'h00, rts}, 8'h00);
        rts_man <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, rts}, 8'h01);
        u_peer.send_char(8'h55, 1'b0);
        repeat (3) @(posedge clk);
        chk(n_ferr[7:0], 8'h01);
        pop(d);
        chk(d, 8'h55);
        repeat (12 * BC) @(posedge clk);
        while (rx_valid === 1'b1) pop(d);
        pdown <= 1'b1;
        repeat (3) @(posedge clk);
        chk({7'h00, clk_run}, 8'h00);
        u_peer.glitch();
        repeat (3) @(posedge clk);
        chk({7'h00, clk_run}, 8'h01);
        chk({7'h00, rx_valid}, 8'h00);
        pdown <= 1'b0;
        end_sim();
    end

    initial begin
        #200000;
        n_mismatch++;
        end_sim();
    end
endmodule
`default_nettype wire
